// ===== ato_aux_if.sv
interface ato_aux_if;
  logic [ato_pkg::SEL_W-1:0] sel;
  logic [ato_pkg::DAC_W-1:0] dac_value;
  logic [ato_pkg::OBS_W-1:0] obs_sel;
  logic [ato_pkg::DAC_W-1:0] dac_code;
  logic dac_en;
  logic level;
  logic oe;

  modport ctrl (
    output sel,
    output dac_value,
    output obs_sel,
    input dac_code,
    input dac_en,
    input level,
    input oe
  );

  modport mux (
    input sel,
    input dac_value,
    input obs_sel,
    output dac_code,
    output dac_en,
    output level,
    output oe
  );
endinterface

// ===== ato_aux_mux.sv
module ato_aux_mux (
  input wire logic clk,
  input wire logic rst_n,
  ato_aux_if.mux ch,
  input wire logic [ato_pkg::DAC_W-1:0] correlator_one_signal,
  input wire logic [ato_pkg::DAC_W-1:0] correlator_two_signal,
  input wire logic [ato_pkg::DAC_W-1:0] minimum_level_signal,
  input wire logic [ato_pkg::SAMPLE_W-1:0] adc_i,
  input wire logic [ato_pkg::SAMPLE_W-1:0] adc_q,
  input wire logic prod_test,
  input wire logic secure_clk,
  input wire logic error_observe_bit,
  input wire logic transmit_active_strobe,
  input wire logic receive_active_strobe,
  input wire logic subcarrier_detected,
  input wire logic rate_106,
  input wire logic [ato_pkg::TEST_BUS_W-1:0] test_bus
);

  typedef struct packed {
    logic [ato_pkg::DAC_W-1:0] dac_code;
    logic dac_en;
    logic level;
    logic oe;
  } ato_mux_state_t;

  ato_mux_state_t r;
  ato_mux_state_t next_r;
  logic [ato_pkg::SAMPLE_W:0] iq_sum;

  assign iq_sum = {1'b0, adc_i} + {1'b0, adc_q};

  always_comb begin
    next_r = '0;
    next_r.oe = 1'b1;
    case (ato_pkg::ato_src_t'(ch.sel))
      ato_pkg::SRC_TRISTATE: next_r.oe = 1'b0;
      ato_pkg::SRC_DAC_VALUE: begin
        next_r.dac_en = 1'b1;
        next_r.dac_code = ch.dac_value;
      end
      ato_pkg::SRC_CORR_ONE: begin
        next_r.dac_en = 1'b1;
        next_r.dac_code = correlator_one_signal;
      end
      ato_pkg::SRC_CORR_TWO: begin
        next_r.dac_en = 1'b1;
        next_r.dac_code = correlator_two_signal;
      end
      ato_pkg::SRC_MIN_LEVEL: begin
        next_r.dac_en = 1'b1;
        next_r.dac_code = minimum_level_signal;
      end
      ato_pkg::SRC_ADC_I: begin
        next_r.dac_en = 1'b1;
        next_r.dac_code = {{(ato_pkg::DAC_W-ato_pkg::SAMPLE_W){1'b0}}, adc_i};
      end
      ato_pkg::SRC_ADC_Q: begin
        next_r.dac_en = 1'b1;
        next_r.dac_code = {{(ato_pkg::DAC_W-ato_pkg::SAMPLE_W){1'b0}}, adc_q};
      end
      ato_pkg::SRC_ADC_IQ: begin
        next_r.dac_en = 1'b1;
        next_r.dac_code = {{(ato_pkg::DAC_W-ato_pkg::SAMPLE_W-1){1'b0}}, iq_sum};
      end
      ato_pkg::SRC_PROD_TEST: next_r.level = prod_test;
      ato_pkg::SRC_SECURE_CLK: next_r.level = secure_clk;
      ato_pkg::SRC_ERROR: next_r.level = error_observe_bit;
      ato_pkg::SRC_LOW: next_r.level = 1'b0;
      ato_pkg::SRC_TX_ACTIVE: next_r.level = transmit_active_strobe;
      ato_pkg::SRC_RX_ACTIVE: next_r.level = receive_active_strobe;
      // no subcarrier indication exists at the lowest rate
      ato_pkg::SRC_SUBCARRIER: next_r.level = subcarrier_detected & ~rate_106;
      ato_pkg::SRC_TEST_BUS: next_r.level = test_bus[ch.obs_sel];
      default: next_r.oe = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ch.dac_code = r.dac_code;
  assign ch.dac_en = r.dac_en;
  assign ch.level = r.level;
  assign ch.oe = r.oe;

endmodule // ato_aux_mux

// ===== ato_pkg.sv
package ato_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int DAC_W = 6;
  localparam int SAMPLE_W = 4;
  localparam int SEL_W = 4;
  localparam int OBS_W = 3;
  localparam int REG_W = 8;
  localparam int BUS_W = 32;
  localparam int TEST_BUS_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_AUX_OUTPUT_CONTROL = 16'h6328;
  localparam logic [15:0] IDX_DAC_ONE_TEST_VALUE = 16'h6329;
  localparam logic [15:0] IDX_DAC_TWO_TEST_VALUE = 16'h632A;
  localparam logic [15:0] IDX_ADC_IQ_SNAPSHOT = 16'h632B;
  localparam logic [15:0] IDX_RF_DETECTOR_CONTROL = 16'h632F;
  localparam logic [15:0] IDX_OBSERVE_BIT_SELECT = 16'h6330;

  localparam logic [1:0] BYTE_ADDR_SHIFT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int AUX_TWO_SEL_LSB = 0;
  localparam int AUX_ONE_SEL_LSB = 4;
  localparam int ADC_Q_LSB = 0;
  localparam int ADC_I_LSB = 4;
  localparam int RF_POWERDOWN_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [REG_W-1:0] AUX_OUTPUT_CONTROL_RST = 8'h00;
  localparam logic [DAC_W-1:0] DAC_VALUE_RST = 6'h00;
  localparam logic [REG_W-1:0] RF_DETECTOR_CONTROL_RST = 8'h00;
  localparam logic [OBS_W-1:0] OBSERVE_BIT_SELECT_RST = 3'h0;

  localparam logic [1:0] HRESP_OKAY = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // source encoding shared by both auxiliary outputs
  typedef enum logic [SEL_W-1:0] {
    SRC_TRISTATE = 4'h0,
    SRC_DAC_VALUE = 4'h1,
    SRC_CORR_ONE = 4'h2,
    SRC_CORR_TWO = 4'h3,
    SRC_MIN_LEVEL = 4'h4,
    SRC_ADC_I = 4'h5,
    SRC_ADC_Q = 4'h6,
    SRC_ADC_IQ = 4'h7,
    SRC_PROD_TEST = 4'h8,
    SRC_SECURE_CLK = 4'h9,
    SRC_ERROR = 4'hA,
    SRC_LOW = 4'hB,
    SRC_TX_ACTIVE = 4'hC,
    SRC_RX_ACTIVE = 4'hD,
    SRC_SUBCARRIER = 4'hE,
    SRC_TEST_BUS = 4'hF
  } ato_src_t;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_CTRL = 3'h1,
    REG_DAC_ONE = 3'h2,
    REG_DAC_TWO = 3'h3,
    REG_ADC = 3'h4,
    REG_RF = 3'h5,
    REG_OBS = 3'h6
  } ato_reg_t;

endpackage

// ===== ato_top.sv
// Decided for this implementation: register access over AHB-Lite.
module ato_top (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [ato_pkg::BUS_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [ato_pkg::BUS_W-1:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [ato_pkg::BUS_W-1:0] HRDATA,
  output logic [1:0] HRESP,
  input wire logic [ato_pkg::DAC_W-1:0] CORRELATOR_ONE_SIGNAL,
  input wire logic [ato_pkg::DAC_W-1:0] CORRELATOR_TWO_SIGNAL,
  input wire logic [ato_pkg::DAC_W-1:0] MINIMUM_LEVEL_SIGNAL,
  input wire logic [ato_pkg::SAMPLE_W-1:0] ADC_I_SAMPLE,
  input wire logic [ato_pkg::SAMPLE_W-1:0] ADC_Q_SAMPLE,
  input wire logic PROD_TEST_SIGNAL,
  input wire logic SECURE_CLK_PIN,
  input wire logic ERROR_OBSERVE_BIT,
  input wire logic TRANSMIT_ACTIVE_STROBE,
  input wire logic RECEIVE_ACTIVE_STROBE,
  input wire logic SUBCARRIER_DETECTED,
  input wire logic RATE_106,
  input wire logic [ato_pkg::TEST_BUS_W-1:0] TEST_BUS,
  output logic [ato_pkg::DAC_W-1:0] ANALOG_OUTPUT_ONE_DAC,
  output logic ANALOG_OUTPUT_ONE_DAC_EN,
  output logic ANALOG_OUTPUT_ONE_LEVEL,
  output logic ANALOG_OUTPUT_ONE_OE,
  output logic [ato_pkg::DAC_W-1:0] ANALOG_OUTPUT_TWO_DAC,
  output logic ANALOG_OUTPUT_TWO_DAC_EN,
  output logic ANALOG_OUTPUT_TWO_LEVEL,
  output logic ANALOG_OUTPUT_TWO_OE,
  output logic RF_DETECTOR_POWERDOWN
);

  //////////////////////////////////////////////////////////////////////////////
  // byte addresses

  localparam logic [ato_pkg::BUS_W-1:0] ADDR_CTRL =
    {16'h0000, ato_pkg::IDX_AUX_OUTPUT_CONTROL} << ato_pkg::BYTE_ADDR_SHIFT;
  localparam logic [ato_pkg::BUS_W-1:0] ADDR_DAC_ONE =
    {16'h0000, ato_pkg::IDX_DAC_ONE_TEST_VALUE} << ato_pkg::BYTE_ADDR_SHIFT;
  localparam logic [ato_pkg::BUS_W-1:0] ADDR_DAC_TWO =
    {16'h0000, ato_pkg::IDX_DAC_TWO_TEST_VALUE} << ato_pkg::BYTE_ADDR_SHIFT;
  localparam logic [ato_pkg::BUS_W-1:0] ADDR_ADC =
    {16'h0000, ato_pkg::IDX_ADC_IQ_SNAPSHOT} << ato_pkg::BYTE_ADDR_SHIFT;
  localparam logic [ato_pkg::BUS_W-1:0] ADDR_RF =
    {16'h0000, ato_pkg::IDX_RF_DETECTOR_CONTROL} << ato_pkg::BYTE_ADDR_SHIFT;
  localparam logic [ato_pkg::BUS_W-1:0] ADDR_OBS =
    {16'h0000, ato_pkg::IDX_OBSERVE_BIT_SELECT} << ato_pkg::BYTE_ADDR_SHIFT;

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic secure_clk_meta;
    logic secure_clk_sync;
    logic [ato_pkg::REG_W-1:0] aux_output_control;
    logic [ato_pkg::DAC_W-1:0] dac_one_value;
    logic [ato_pkg::DAC_W-1:0] dac_two_value;
    logic [ato_pkg::REG_W-1:0] rf_detector_control;
    logic [ato_pkg::OBS_W-1:0] observe_bit_select;
    logic ph_valid;
    logic ph_write;
    ato_pkg::ato_reg_t ph_reg;
    logic [ato_pkg::BUS_W-1:0] hrdata;
    logic hreadyout;
    logic powerdown;
  } ato_state_t;

  ato_state_t r;
  ato_state_t next_r;

  ato_aux_if aux_one ();
  ato_aux_if aux_two ();

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic ato_pkg::ato_reg_t decode(input logic [ato_pkg::BUS_W-1:0] addr);
    ato_pkg::ato_reg_t sel;
    sel = ato_pkg::REG_NONE;
    if (addr == ADDR_CTRL) begin
      sel = ato_pkg::REG_CTRL;
    end else if (addr == ADDR_DAC_ONE) begin
      sel = ato_pkg::REG_DAC_ONE;
    end else if (addr == ADDR_DAC_TWO) begin
      sel = ato_pkg::REG_DAC_TWO;
    end else if (addr == ADDR_ADC) begin
      sel = ato_pkg::REG_ADC;
    end else if (addr == ADDR_RF) begin
      sel = ato_pkg::REG_RF;
    end else if (addr == ADDR_OBS) begin
      sel = ato_pkg::REG_OBS;
    end
    return sel;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // read data, zero-extended into the word

  function automatic logic [ato_pkg::BUS_W-1:0] read_word(
    input ato_pkg::ato_reg_t sel,
    input ato_state_t s,
    input logic [ato_pkg::REG_W-1:0] snapshot
  );
    logic [ato_pkg::BUS_W-1:0] word;
    word = '0;
    case (sel)
      ato_pkg::REG_CTRL: begin
        word[ato_pkg::REG_W-1:0] = s.aux_output_control;
      end
      ato_pkg::REG_DAC_ONE: begin
        word[ato_pkg::DAC_W-1:0] = s.dac_one_value;
      end
      ato_pkg::REG_DAC_TWO: begin
        word[ato_pkg::DAC_W-1:0] = s.dac_two_value;
      end
      ato_pkg::REG_ADC: begin
        word[ato_pkg::REG_W-1:0] = snapshot;
      end
      ato_pkg::REG_RF: begin
        word[ato_pkg::REG_W-1:0] = s.rf_detector_control;
      end
      ato_pkg::REG_OBS: begin
        word[ato_pkg::OBS_W-1:0] = s.observe_bit_select;
      end
      default: word = '0;
    endcase
    return word;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic [ato_pkg::REG_W-1:0] adc_snapshot;
  logic write_now;

  always_comb begin
    adc_snapshot = '0;
    adc_snapshot[ato_pkg::ADC_I_LSB +: ato_pkg::SAMPLE_W] = ADC_I_SAMPLE;
    adc_snapshot[ato_pkg::ADC_Q_LSB +: ato_pkg::SAMPLE_W] = ADC_Q_SAMPLE;
  end

  assign write_now = r.ph_valid & r.ph_write;

  always_comb begin
    next_r = r;
    next_r.secure_clk_meta = SECURE_CLK_PIN;
    next_r.secure_clk_sync = r.secure_clk_meta;
    next_r.hreadyout = 1'b1;

    // data phase of a write: hwdata is valid now
    if (write_now) begin
      case (r.ph_reg)
        ato_pkg::REG_CTRL: begin
          next_r.aux_output_control = HWDATA[ato_pkg::REG_W-1:0];
        end
        ato_pkg::REG_DAC_ONE: begin
          next_r.dac_one_value = HWDATA[ato_pkg::DAC_W-1:0];
        end
        ato_pkg::REG_DAC_TWO: begin
          next_r.dac_two_value = HWDATA[ato_pkg::DAC_W-1:0];
        end
        ato_pkg::REG_RF: begin
          next_r.rf_detector_control = HWDATA[ato_pkg::REG_W-1:0];
        end
        ato_pkg::REG_OBS: begin
          next_r.observe_bit_select = HWDATA[ato_pkg::OBS_W-1:0];
        end
        default: begin
          next_r.ph_valid = r.ph_valid;
        end
      endcase
    end

    next_r.powerdown = next_r.rf_detector_control[ato_pkg::RF_POWERDOWN_BIT];

    // address phase
    next_r.ph_valid = HSEL & HTRANS[1] & HREADY;
    next_r.ph_write = HWRITE;
    next_r.ph_reg = decode(HADDR);

    // read data from post-write values so a write followed by a read returns the new value
    next_r.hrdata = '0;
    if (next_r.ph_valid && !HWRITE) begin
      next_r.hrdata = read_word(next_r.ph_reg, next_r, adc_snapshot);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      r <= '0;
      r.aux_output_control <= ato_pkg::AUX_OUTPUT_CONTROL_RST;
      r.dac_one_value <= ato_pkg::DAC_VALUE_RST;
      r.dac_two_value <= ato_pkg::DAC_VALUE_RST;
      r.rf_detector_control <= ato_pkg::RF_DETECTOR_CONTROL_RST;
      r.observe_bit_select <= ato_pkg::OBSERVE_BIT_SELECT_RST;
      r.hreadyout <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // selector fields go out from next values so the mux acts at the write's edge

  assign aux_one.sel = next_r.aux_output_control[ato_pkg::AUX_ONE_SEL_LSB +: ato_pkg::SEL_W];
  assign aux_one.dac_value = next_r.dac_one_value;
  assign aux_one.obs_sel = next_r.observe_bit_select;
  assign aux_two.sel = next_r.aux_output_control[ato_pkg::AUX_TWO_SEL_LSB +: ato_pkg::SEL_W];
  assign aux_two.dac_value = next_r.dac_two_value;
  assign aux_two.obs_sel = next_r.observe_bit_select;

  //////////////////////////////////////////////////////////////////////////////
  // output muxes

  ato_aux_mux u_aux_one (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .ch(aux_one.mux),
    .correlator_one_signal(CORRELATOR_ONE_SIGNAL),
    .correlator_two_signal(CORRELATOR_TWO_SIGNAL),
    .minimum_level_signal(MINIMUM_LEVEL_SIGNAL),
    .adc_i(ADC_I_SAMPLE),
    .adc_q(ADC_Q_SAMPLE),
    .prod_test(PROD_TEST_SIGNAL),
    .secure_clk(r.secure_clk_sync),
    .error_observe_bit(ERROR_OBSERVE_BIT),
    .transmit_active_strobe(TRANSMIT_ACTIVE_STROBE),
    .receive_active_strobe(RECEIVE_ACTIVE_STROBE),
    .subcarrier_detected(SUBCARRIER_DETECTED),
    .rate_106(RATE_106),
    .test_bus(TEST_BUS)
  );

  ato_aux_mux u_aux_two (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .ch(aux_two.mux),
    .correlator_one_signal(CORRELATOR_ONE_SIGNAL),
    .correlator_two_signal(CORRELATOR_TWO_SIGNAL),
    .minimum_level_signal(MINIMUM_LEVEL_SIGNAL),
    .adc_i(ADC_I_SAMPLE),
    .adc_q(ADC_Q_SAMPLE),
    .prod_test(PROD_TEST_SIGNAL),
    .secure_clk(r.secure_clk_sync),
    .error_observe_bit(ERROR_OBSERVE_BIT),
    .transmit_active_strobe(TRANSMIT_ACTIVE_STROBE),
    .receive_active_strobe(RECEIVE_ACTIVE_STROBE),
    .subcarrier_detected(SUBCARRIER_DETECTED),
    .rate_106(RATE_106),
    .test_bus(TEST_BUS)
  );

  //////////////////////////////////////////////////////////////////////////////
  // ports

  assign HREADYOUT = r.hreadyout;
  assign HRDATA = r.hrdata;
  assign HRESP = ato_pkg::HRESP_OKAY;
  assign RF_DETECTOR_POWERDOWN = r.powerdown;
  assign ANALOG_OUTPUT_ONE_DAC = aux_one.dac_code;
  assign ANALOG_OUTPUT_ONE_DAC_EN = aux_one.dac_en;
  assign ANALOG_OUTPUT_ONE_LEVEL = aux_one.level;
  assign ANALOG_OUTPUT_ONE_OE = aux_one.oe;
  assign ANALOG_OUTPUT_TWO_DAC = aux_two.dac_code;
  assign ANALOG_OUTPUT_TWO_DAC_EN = aux_two.dac_en;
  assign ANALOG_OUTPUT_TWO_LEVEL = aux_two.level;
  assign ANALOG_OUTPUT_TWO_OE = aux_two.oe;

endmodule // ato_top

// ===== ato_top_checker.sv
module ato_top_checker (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [ato_pkg::BUS_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [ato_pkg::BUS_W-1:0] HWDATA,
  input wire logic HREADY,
  input wire logic [ato_pkg::BUS_W-1:0] HRDATA,
  input wire logic [ato_pkg::SAMPLE_W-1:0] ADC_I_SAMPLE,
  input wire logic [ato_pkg::SAMPLE_W-1:0] ADC_Q_SAMPLE,
  input wire logic ANALOG_OUTPUT_ONE_DAC_EN,
  input wire logic ANALOG_OUTPUT_TWO_DAC_EN,
  input wire logic ANALOG_OUTPUT_TWO_LEVEL,
  input wire logic ANALOG_OUTPUT_TWO_OE,
  input wire logic RF_DETECTOR_POWERDOWN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic dp_wr;
  logic dp_rd;
  logic [15:0] dp_idx;
  logic ctl_wr;
  ////////////////////////////////////////
  // data-phase tracker
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      dp_wr <= 1'h0;
      dp_rd <= 1'h0;
      dp_idx <= 16'h0000;
    end else if (HREADY) begin
      dp_wr <= HSEL && HTRANS[1] && HWRITE;
      dp_rd <= HSEL && HTRANS[1] && !HWRITE;
      dp_idx <= HADDR[17:2];
    end
  end
  assign ctl_wr = dp_wr && (dp_idx == ato_pkg::IDX_AUX_OUTPUT_CONTROL);
  ////////////////////////////////////////
  chk_tristate_quiet: assert property (
    !ANALOG_OUTPUT_TWO_OE |-> !ANALOG_OUTPUT_TWO_DAC_EN && !ANALOG_OUTPUT_TWO_LEVEL)
    else $error("tristated output still active");
  chk_dac_driven: assert property (
    ANALOG_OUTPUT_TWO_DAC_EN |-> ANALOG_OUTPUT_TWO_OE && !ANALOG_OUTPUT_TWO_LEVEL)
    else $error("dac code without drive");
  chk_sel_off: assert property (
    ctl_wr && HWDATA[3:0] == 4'h0 |=> !ANALOG_OUTPUT_TWO_OE)
    else $error("code zero did not tristate");
  chk_sel_next_edge: assert property (
    ctl_wr && HWDATA[3:0] != 4'h0 |=> ANALOG_OUTPUT_TWO_OE)
    else $error("selector write not effective at next edge");
  chk_two_dac_code: assert property (
    ctl_wr && HWDATA[3:0] != 4'h0 && !HWDATA[3] |=> ANALOG_OUTPUT_TWO_DAC_EN)
    else $error("dac code not selected on output two");
  chk_one_dac_code: assert property (
    ctl_wr && HWDATA[7:4] == 4'h1 |=> ANALOG_OUTPUT_ONE_DAC_EN)
    else $error("dac one not selected on output one");
  chk_low_code: assert property (
    ctl_wr && HWDATA[3:0] == 4'hB |=> !ANALOG_OUTPUT_TWO_LEVEL && !ANALOG_OUTPUT_TWO_DAC_EN)
    else $error("low code not low");
  chk_rf_powerdown: assert property (
    dp_wr && dp_idx == ato_pkg::IDX_RF_DETECTOR_CONTROL
    |=> RF_DETECTOR_POWERDOWN == $past(HWDATA[4]))
    else $error("powerdown does not follow bit 4");
  chk_adc_snapshot: assert property (
    dp_rd && dp_idx == ato_pkg::IDX_ADC_IQ_SNAPSHOT
    |-> HRDATA == {24'h000000, $past(ADC_I_SAMPLE), $past(ADC_Q_SAMPLE)})
    else $error("snapshot read mismatch");
  chk_dac_upper_zero: assert property (
    dp_rd && dp_idx == ato_pkg::IDX_DAC_ONE_TEST_VALUE |-> HRDATA[31:6] == 26'h0)
    else $error("dac one upper bits not zero");
endmodule // ato_top_checker

// ===== ato_top_tb.sv
module ato_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  logic [5:0] cor_one = 6'h00;
  logic [5:0] cor_two = 6'h00;
  logic [5:0] minlvl = 6'h00;
  logic [3:0] adc_i = 4'h0;
  logic [3:0] adc_q = 4'h0;
  logic prod = 1'h0;
  logic sclk = 1'h0;
  logic errb = 1'h0;
  logic txa = 1'h0;
  logic rxa = 1'h0;
  logic subc = 1'h0;
  logic rate106 = 1'h0;
  logic [7:0] tbus = 8'h00;
  logic [5:0] a1_dac;
  logic [5:0] a2_dac;
  logic a1_en, a1_lv, a1_oe, a2_en, a2_lv, a2_oe, pd;
  logic [31:0] rd_q[$];
  logic [18:0] ax_q[$];
  logic rd_chk = 1'h0;
  logic ax_chk = 1'h0;
  logic [5:0] d1 = 6'h00;
  logic [5:0] d2 = 6'h00;
  logic [2:0] obs = 3'h0;
  logic exp_pd = 1'h0;
  int err_count = 0;
  int comparisons = 0;
  assign hready = hreadyout;
  always #2.5 sys_clk = ~sys_clk;
  ato_top ato_top_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
    .CORRELATOR_ONE_SIGNAL(cor_one), .CORRELATOR_TWO_SIGNAL(cor_two),
    .MINIMUM_LEVEL_SIGNAL(minlvl), .ADC_I_SAMPLE(adc_i), .ADC_Q_SAMPLE(adc_q),
    .PROD_TEST_SIGNAL(prod), .SECURE_CLK_PIN(sclk), .ERROR_OBSERVE_BIT(errb),
    .TRANSMIT_ACTIVE_STROBE(txa), .RECEIVE_ACTIVE_STROBE(rxa),
    .SUBCARRIER_DETECTED(subc), .RATE_106(rate106), .TEST_BUS(tbus),
    .ANALOG_OUTPUT_ONE_DAC(a1_dac), .ANALOG_OUTPUT_ONE_DAC_EN(a1_en),
    .ANALOG_OUTPUT_ONE_LEVEL(a1_lv), .ANALOG_OUTPUT_ONE_OE(a1_oe),
    .ANALOG_OUTPUT_TWO_DAC(a2_dac), .ANALOG_OUTPUT_TWO_DAC_EN(a2_en),
    .ANALOG_OUTPUT_TWO_LEVEL(a2_lv), .ANALOG_OUTPUT_TWO_OE(a2_oe),
    .RF_DETECTOR_POWERDOWN(pd));
  ////////////////////////////////////////
  task automatic conclude();
    $display("comparisons=%0d errors=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] a);
    comparisons++;
    if (a !== e) begin
      err_count++;
      $display("Error t=%0t read exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic cmp_ax(input logic [18:0] e, input logic [18:0] a);
    comparisons++;
    if (a !== e) begin
      err_count++;
      $display("Error t=%0t aux exp=%h got=%h", $time, e, a);
    end
  endtask
  // output watcher: takes the oldest note whenever a result is due
  always @(posedge sys_clk) begin
    if (rd_chk && hready) cmp_rd(rd_q.pop_front(), hrdata);
    if (ax_chk) cmp_ax(ax_q.pop_front(), {pd, a1_oe, a1_en, a1_lv, a1_dac,
      a2_oe, a2_en, a2_lv, a2_dac});
  end
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'h1) begin
      n++;
      if (n > 50) begin
        err_count++;
        conclude();
      end
      @(posedge sys_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_chk <= !wr;
    wait_rdy();
    rd_chk <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'h0, idx, 32'h0);
  endtask
  function automatic logic [8:0] aux_exp(input logic [3:0] c, input logic [5:0] dv);
    logic [5:0] d;
    logic l;
    d = 6'h00;
    l = 1'h0;
    case (c)
      4'h1: d = dv;
      4'h2: d = cor_one;
      4'h3: d = cor_two;
      4'h4: d = minlvl;
      4'h5: d = {2'h0, adc_i};
      4'h6: d = {2'h0, adc_q};
      4'h7: d = {1'h0, {1'h0, adc_i} + {1'h0, adc_q}};
      4'h8: l = prod;
      4'h9: l = sclk;
      4'hA: l = errb;
      4'hC: l = txa;
      4'hD: l = rxa;
      4'hE: l = subc & ~rate106;
      4'hF: l = tbus[obs];
      default: l = 1'h0;
    endcase
    return {c != 4'h0, c != 4'h0 && !c[3], l, d};
  endfunction
  task automatic expect_ax(input logic [3:0] c1, input logic [3:0] c2);
    ax_q.push_back({exp_pd, aux_exp(c1, d1), aux_exp(c2, d2)});
    ax_chk <= 1'h1;
    @(posedge sys_clk);
    ax_chk <= 1'h0;
  endtask
  ////////////////////////////////////////
  initial begin
    int k;
    logic [3:0] c;
    logic [31:0] w;
    logic [63:0] r;
    void'($urandom(41589));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rd(ato_pkg::IDX_AUX_OUTPUT_CONTROL, 32'h0);
    rd(ato_pkg::IDX_DAC_ONE_TEST_VALUE, 32'h0);
    rd(ato_pkg::IDX_RF_DETECTOR_CONTROL, 32'h0);
    expect_ax(4'h0, 4'h0);
    $display("test reset done");
    w = $urandom;
    d1 = w[5:0];
    bus(1'h1, ato_pkg::IDX_DAC_ONE_TEST_VALUE, w);
    rd(ato_pkg::IDX_DAC_ONE_TEST_VALUE, {26'h0, d1});
    w = $urandom;
    d2 = w[5:0];
    bus(1'h1, ato_pkg::IDX_DAC_TWO_TEST_VALUE, w);
    rd(ato_pkg::IDX_DAC_TWO_TEST_VALUE, {26'h0, d2});
    obs = 3'($urandom);
    bus(1'h1, ato_pkg::IDX_OBSERVE_BIT_SELECT, {29'h0, obs});
    bus(1'h1, 16'h632C, $urandom);
    rd(16'h632C, 32'h0);
    $display("test registers done");
    for (k = 0; k < 32; k++) begin
      c = k[3:0];
      r = {$urandom, $urandom};
      {cor_one, cor_two, minlvl, adc_i, adc_q, prod, sclk, errb, txa, rxa, subc, tbus} <= r[39:0];
      rate106 <= k[4];
      bus(1'h1, ato_pkg::IDX_AUX_OUTPUT_CONTROL, {24'h0, ~c, c});
      // secure clock path needs three edges
      repeat (4) @(posedge sys_clk);
      expect_ax(~c, c);
    end
    $display("test source sweep done");
    bus(1'h1, ato_pkg::IDX_ADC_IQ_SNAPSHOT, $urandom);
    rd(ato_pkg::IDX_ADC_IQ_SNAPSHOT, {24'h0, adc_i, adc_q});
    rd(ato_pkg::IDX_AUX_OUTPUT_CONTROL, {24'h0, ~c, c});
    bus(1'h1, ato_pkg::IDX_RF_DETECTOR_CONTROL, 32'h10);
    exp_pd = 1'h1;
    rd(ato_pkg::IDX_RF_DETECTOR_CONTROL, 32'h10);
    expect_ax(~c, c);
    bus(1'h1, ato_pkg::IDX_RF_DETECTOR_CONTROL, 32'h0);
    exp_pd = 1'h0;
    rd(ato_pkg::IDX_RF_DETECTOR_CONTROL, 32'h0);
    expect_ax(~c, c);
    $display("test snapshot and detector done");
    // reset in mid-run must clear the detector bit and both selectors
    bus(1'h1, ato_pkg::IDX_RF_DETECTOR_CONTROL, 32'h10);
    rst_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    exp_pd = 1'h0;
    @(posedge sys_clk);
    rd(ato_pkg::IDX_RF_DETECTOR_CONTROL, 32'h0);
    rd(ato_pkg::IDX_AUX_OUTPUT_CONTROL, 32'h0);
    expect_ax(4'h0, 4'h0);
    $display("test mid-run reset done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
endmodule // ato_top_tb

bind ato_top ato_top_checker ato_top_checker_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA), .ADC_I_SAMPLE(ADC_I_SAMPLE),
  .ADC_Q_SAMPLE(ADC_Q_SAMPLE), .ANALOG_OUTPUT_ONE_DAC_EN(ANALOG_OUTPUT_ONE_DAC_EN),
  .ANALOG_OUTPUT_TWO_DAC_EN(ANALOG_OUTPUT_TWO_DAC_EN),
  .ANALOG_OUTPUT_TWO_LEVEL(ANALOG_OUTPUT_TWO_LEVEL),
  .ANALOG_OUTPUT_TWO_OE(ANALOG_OUTPUT_TWO_OE),
  .RF_DETECTOR_POWERDOWN(RF_DETECTOR_POWERDOWN));
